// file: port_two_map.svh
/*
 Register offsets, reset values and timing figures of the port.
 Assumes a 16-bit register address taken as printed.
*/
`ifndef PORT_TWO_MAP_SVH
`define PORT_TWO_MAP_SVH
// Register offsets
`define ODC_OFS      16'hF1C2
`define DATA_OFS     16'hFFC0
`define DIR_OFS      16'hFFC2
// Reset values
`define ODC_RST      16'h0000
`define DATA_RST     16'h0000
`define DIR_RST      16'h0000
// Clock rate and interrupt sampling periods
`define CLK_MHZ      250
`define SLOW_PS      250000
`define FAST_PS      31250
`define SLOW_CYC     ((`SLOW_PS * `CLK_MHZ) / 1000000)
`define FAST_CYC     ((`FAST_PS * `CLK_MHZ) / 1000000)
// Line positions
`define FAST_LO      8
`define TIMER_LINE   15
`endif

// file: port_two_pkg.sv
/*
 Types shared by the port logic.
 Assumes port_two_map.svh is compiled alongside.
*/
package port_two_pkg;
	typedef enum logic [1:0] {
		CMP_OFF    = 2'b00,
		CMP_TOGGLE = 2'b01,
		CMP_SET    = 2'b11
	} cmp_mode_t;

	// One compare request per line from the capture/compare unit
	typedef struct packed {
		logic [15:0] trig;
		logic [15:0] ovf;
		logic [15:0] mode_set;
	} capcom_req_t;

	typedef struct packed {
		logic [15:0] data;
		logic [15:0] oe_n;
	} pin_drive_t;
endpackage

// file: port_two_io.sv
/*
 Sixteen-line I/O port with data latch, direction and open-drain
 registers, compare output path and capture/interrupt inputs.
 Assumes pins are asynchronous and the register port is synchronous.
*/
`timescale 1ns/1ps
`include "port_two_map.svh"

module port_two_io
	import port_two_pkg::*;
#(
	parameter int SLOW_CYC = `SLOW_CYC,
	parameter int FAST_CYC = `FAST_CYC
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// Register port
	input  wire logic [15:0] addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	// Capture/compare unit
	input  capcom_req_t      capcom_i,
	output logic      [15:0] capture_src_o,
	output logic      [15:0] ext_int_o,
	output logic      [7:0]  fast_int_o,
	output logic             timer_seven_count_o,
	// Pins
	input  wire logic [15:0] pin_i,
	output logic      [15:0] pin_o,
	output logic      [15:0] pin_oe_n_o
);

	function automatic logic hit(input logic [15:0] a,
		input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction

	logic [15:0] port_two_data_latch;
	logic [15:0] port_two_direction;
	logic [15:0] port_two_open_drain_control;
	logic [15:0] pin_meta;
	logic [15:0] pin_sync;
	logic [15:0] next_latch;
	logic [15:0] capture_level;
	logic [7:0]  slow_cnt;
	logic [7:0]  fast_cnt;
	logic        data_wr;
	pin_drive_t  next_drive;

	// Last count of one fast sampling period, for the period check
	localparam int FAST_LAST = FAST_CYC - 1;

	assign data_wr = wr_i && hit(addr_i, `DATA_OFS);

	// Pin synchroniser
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_meta <= 16'h0000;
			pin_sync <= 16'h0000;
		end else begin
			pin_meta <= pin_i;
			pin_sync <= pin_meta;
		end
	end

	// Latch input multiplexer per line
	genvar y;
	generate
		for (y = 0; y < 16; y++) begin : g_line
			always_comb begin
				if (data_wr) begin
					next_latch[y] = wdata_i[y];
				end else if (capcom_i.trig[y]) begin
					if (capcom_i.mode_set[y]) begin
						next_latch[y] = ~capcom_i.ovf[y];
					end else begin
						next_latch[y] = ~port_two_data_latch[y];
					end
				end else begin
					next_latch[y] = port_two_data_latch[y];
				end
			end
		end
	endgenerate

	// Data latch
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			port_two_data_latch <= `DATA_RST;
		end else begin
			port_two_data_latch <= next_latch;
		end
	end

	// Direction and open-drain registers
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			port_two_direction          <= `DIR_RST;
			port_two_open_drain_control <= `ODC_RST;
		end else begin
			if (wr_i && hit(addr_i, `DIR_OFS)) begin
				port_two_direction <= wdata_i;
			end
			if (wr_i && hit(addr_i, `ODC_OFS)) begin
				port_two_open_drain_control <= wdata_i;
			end
		end
	end

	// Read data, valid the cycle after the strobe only
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_o <= 16'h0000;
		end else if (!rd_i) begin
			rdata_o <= 16'h0000;
		end else if (hit(addr_i, `DATA_OFS)) begin
			rdata_o <= port_two_data_latch;
		end else if (hit(addr_i, `DIR_OFS)) begin
			rdata_o <= port_two_direction;
		end else if (hit(addr_i, `ODC_OFS)) begin
			rdata_o <= port_two_open_drain_control;
		end else begin
			rdata_o <= 16'h0000;
		end
	end

	// Pin drivers
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			next_drive.data[i] = port_two_data_latch[i] &
				~port_two_open_drain_control[i];
			next_drive.oe_n[i] = ~port_two_direction[i] |
				(port_two_open_drain_control[i] &
				port_two_data_latch[i]);
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_o      <= 16'h0000;
			pin_oe_n_o <= 16'hFFFF;
		end else begin
			pin_o      <= next_drive.data;
			pin_oe_n_o <= next_drive.oe_n;
		end
	end

	// Capture source: latch for outputs, pin for inputs
	assign capture_level = (port_two_direction & port_two_data_latch) |
		(~port_two_direction & pin_sync);

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			capture_src_o <= 16'h0000;
		end else begin
			capture_src_o <= capture_level;
		end
	end

	// Interrupt sampling periods
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			slow_cnt <= 8'h00;
			fast_cnt <= 8'h00;
		end else begin
			if (slow_cnt == 8'(SLOW_CYC - 1)) begin
				slow_cnt <= 8'h00;
			end else begin
				slow_cnt <= slow_cnt + 8'h01;
			end
			if (fast_cnt == 8'(FAST_CYC - 1)) begin
				fast_cnt <= 8'h00;
			end else begin
				fast_cnt <= fast_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ext_int_o <= 16'h0000;
		end else if (slow_cnt == 8'(SLOW_CYC - 1)) begin
			ext_int_o <= capture_level;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			fast_int_o <= 8'h00;
		end else if (fast_cnt == 8'(FAST_CYC - 1)) begin
			fast_int_o <= pin_sync[15:`FAST_LO];
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			timer_seven_count_o <= 1'b0;
		end else begin
			timer_seven_count_o <= pin_sync[`TIMER_LINE];
		end
	end

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	AST_CPU_WINS: assert property (
		data_wr |=> port_two_data_latch == $past(wdata_i))
		else $error("cpu write lost to compare trigger");

	AST_TOGGLE: assert property (
		!data_wr && capcom_i.trig[0] && !capcom_i.mode_set[0]
		|=> port_two_data_latch[0] != $past(port_two_data_latch[0]))
		else $error("toggle compare did not invert line 0");

	AST_SET_ONE: assert property (
		!data_wr && capcom_i.trig[3] && capcom_i.mode_set[3]
		&& !capcom_i.ovf[3] |=> port_two_data_latch[3])
		else $error("mode 3 match did not set line 3");

	AST_OVF_ZERO: assert property (
		!data_wr && capcom_i.trig[3] && capcom_i.mode_set[3]
		&& capcom_i.ovf[3] |=> !port_two_data_latch[3])
		else $error("overflow did not clear line 3");

	AST_HOLD: assert property (
		!wr_i && capcom_i.trig == 16'h0000
		|=> $stable(port_two_data_latch))
		else $error("latch changed without trigger or write");

	AST_INPUT_HIZ: assert property (
		!port_two_direction[5] ##1 !port_two_direction[5]
		|-> pin_oe_n_o[5])
		else $error("input line 5 is driven");

	AST_OD_RELEASE: assert property (
		port_two_open_drain_control[7] && port_two_data_latch[7]
		|=> pin_oe_n_o[7])
		else $error("open-drain one is driven");

	AST_PUSH_HIGH: assert property (
		port_two_direction[2] && !port_two_open_drain_control[2]
		&& port_two_data_latch[2]
		|=> !pin_oe_n_o[2] && pin_o[2])
		else $error("push-pull one not driven high");

	AST_CAP_OUT: assert property (
		port_two_direction[4]
		|=> capture_src_o[4] == $past(port_two_data_latch[4]))
		else $error("capture does not follow latch");

	AST_CAP_IN: assert property (
		!port_two_direction[9]
		|=> capture_src_o[9] == $past(pin_sync[9]))
		else $error("capture does not follow pin");

	AST_FAST_PERIOD: assert property (
		fast_cnt == 8'h00 |-> ##FAST_LAST
		fast_cnt == 8'(FAST_CYC - 1))
		else $error("fast sampling period wrong");

	AST_TIMER: assert property (
		##1 timer_seven_count_o == $past(pin_sync[15]))
		else $error("timer seven input not tracking line 15");

	AST_EXT_SAMPLE: assert property (
		slow_cnt == 8'(SLOW_CYC - 1)
		|=> ext_int_o == $past(capture_level))
		else $error("interrupt snapshot missed capture level");

	AST_EXT_HOLD: assert property (
		slow_cnt != 8'(SLOW_CYC - 1) |=> $stable(ext_int_o))
		else $error("interrupt snapshot changed between ticks");

	AST_FAST_SAMPLE: assert property (
		fast_cnt == 8'(FAST_CYC - 1)
		|=> fast_int_o == $past(pin_sync[15:`FAST_LO]))
		else $error("fast interrupt snapshot missed pin level");

	AST_DRIVE_LOW: assert property (
		port_two_direction[6] && !port_two_data_latch[6]
		|=> !pin_oe_n_o[6] && !pin_o[6])
		else $error("output zero not driven low");

endmodule // port_two_io

// file: pin_partner.sv
/*
 Pin-side partner: pull-ups plus an external driver per line.
 Assumes the port drives with active-low output enables.
*/
`timescale 1ns/1ps
module pin_partner (
	// Port drive
	input  wire logic [15:0] drv_data_i,
	input  wire logic [15:0] drv_oe_n_i,
	// External driver
	input  wire logic [15:0] ext_en_i,
	input  wire logic [15:0] ext_val_i,
	// Wire level
	output logic      [15:0] level_o
);
	// External device backs off wherever the port drives
	wire logic [15:0] ext_on = ext_en_i & drv_oe_n_i;
	// Released lines float high through pull-ups
	assign level_o = (~drv_oe_n_i & drv_data_i) | (ext_on & ext_val_i)
		| (drv_oe_n_i & ~ext_on);
endmodule // pin_partner

// file: port_two_capture_compare_io_test.sv
/*
 Self-checking bench for the port with a reference model.
 Assumes pin_partner and the port package are compiled first.
*/
`timescale 1ns/1ps
module port_two_capture_compare_io_test;
	import port_two_pkg::*;
	logic        clk_i, reset_i, wr_i, rd_i, timer_seven_count_o;
	logic [15:0] addr_i, wdata_i, rdata_o, capture_src_o, ext_int_o;
	logic [15:0] pin_i, pin_o, pin_oe_n_o, ext_en, ext_val;
	logic [15:0] m_lat, m_dir, m_odc, d;
	logic [7:0]  fast_int_o;
	capcom_req_t capcom_i;
	int          fails, n_tests, n;

	port_two_io DUT (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.capcom_i(capcom_i), .capture_src_o(capture_src_o),
		.ext_int_o(ext_int_o), .fast_int_o(fast_int_o),
		.timer_seven_count_o(timer_seven_count_o), .pin_i(pin_i),
		.pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o));
	pin_partner far (.drv_data_i(pin_o), .drv_oe_n_i(pin_oe_n_o),
		.ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pin_i));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		check(rdata_o, exp);
	endtask

	// Waits past the slow sampling period, then compares every output except rdata_o
	task automatic check_all();
		logic [15:0] lvl, oe;
		repeat (70) @(posedge clk_i);
		@(negedge clk_i);
		lvl = m_dir & m_lat | ~m_dir & (ext_en & ext_val | ~ext_en);
		oe = ~m_dir | m_odc & m_lat;
		check(pin_oe_n_o, oe);
		check(pin_o & ~oe, m_lat & ~m_odc & ~oe);
		check(capture_src_o, lvl);
		check(ext_int_o, lvl);
		check({8'h00, fast_int_o}, {8'h00, lvl[15:8]});
		check({15'h0000, timer_seven_count_o}, {15'h0000, lvl[15]});
	endtask

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		wrap_up();
	end

	initial begin
		{reset_i, wr_i, rd_i} = 3'h4;
		{addr_i, wdata_i, ext_en, ext_val} = '0;
		capcom_i = '0;
		{m_lat, m_dir, m_odc, fails, n_tests} = '0;
		n = $urandom(32'hA6CF7684);
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(16'hF1C2, 16'h0000);
		rd(16'hFFC0, 16'h0000);
		rd(16'hFFC2, 16'h0000);
		rd(16'h1234, 16'h0000);
		check_all();
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			{m_dir, m_odc, m_lat, d} = {$urandom, $urandom};
			@(posedge clk_i);
			ext_en <= 16'($urandom) & ~m_dir;
			ext_val <= d;
			wr(16'hFFC2, m_dir);
			wr(16'hF1C2, m_odc);
			wr(16'hFFC0, m_lat);
			wr(16'hFFC4, 16'($urandom));
			rd(16'hFFC2, m_dir);
			rd(16'hF1C2, m_odc);
			rd(16'hFFC0, m_lat);
			check_all();
		end
		$display("test registers done");
		@(posedge clk_i);
		ext_en <= 16'h0000;
		m_dir = 16'hFFFF;
		wr(16'hFFC2, m_dir);
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_i);
			capcom_i <= {16'($urandom), 16'($urandom), 16'($urandom)};
			d = 16'($urandom);
			if (i % 4 == 3) begin
				addr_i <= 16'hFFC0;
				wdata_i <= d;
				wr_i <= 1'b1;
			end
			@(posedge clk_i);
			capcom_i <= '0;
			wr_i <= 1'b0;
			if (i % 4 == 3)
				m_lat = d;
			else
				m_lat = m_lat & ~capcom_i.trig | capcom_i.trig
					& (capcom_i.mode_set & ~capcom_i.ovf
					| ~capcom_i.mode_set & ~m_lat);
			rd(16'hFFC0, m_lat);
			if (i % 4 == 0)
				check_all();
		end
		$display("test compare done");
		wrap_up();
	end
endmodule // port_two_capture_compare_io_test
